// File: hdl/crol_params.svh
// Register offsets, field positions and reset values for the relay output latch.
`ifndef CROL_PARAMS_SVH
`define CROL_PARAMS_SVH
`define CROL_OFF_LOW      12'h000
`define CROL_OFF_HIGH     12'h004
`define CROL_OFF_SET      12'h008
`define CROL_OFF_STATUS   12'h00C
`define CROL_BIT_MODE     0
`define CROL_BIT_ENABLE   1
`define CROL_HALF_W       16
`define CROL_RELAY_W      32
`define CROL_RST_HALF     16'h0000
`define CROL_CARD_ID      16'hA5C3  // Card tag; the value is arbitrary.
`endif

// File: hdl/crol_pkg.sv
// Types shared by the relay output latch modules.
package crol_pkg;
  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } crol_apb_req_s;
  typedef logic [15:0] crol_half_t;
endpackage

// File: hdl/crol_half_latch.sv
// One 16-bit edge-triggered output latch half, loaded by its write strobe.
`timescale 1ns/1ps
`include "crol_params.svh"
module crol_half_latch
  import crol_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // Strobe and data.
  input  wire logic       load_in,
  input  wire crol_pkg::crol_half_t data_in,
  // Stored half.
  output crol_pkg::crol_half_t      q_out
);
  crol_half_t q_r;

  // The latch loads only on its own strobe and holds otherwise.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      q_r <= `CROL_RST_HALF;  // [RULE10]
    else if (load_in)
      q_r <= data_in;         // [RULE9]
  end

  assign q_out = q_r;
endmodule

// File: hdl/crol_top.sv
// Comparator relay output latch: APB slave, two latch halves, mode and enable.
// What this block does
// [RULE1] Thirty-two relay bits, one closes contact.
// [RULE2] Mode zero: written results drive relays directly.
// [RULE3] Mode one: relay equals result AND enable.
// [RULE4] Address decode gives data and setting strobes.
// [RULE5] Card status readable over the bus.
// [RULE6] Mode and enable are separate setting flip-flops.
// [RULE7] Each write updates only its sixteen lines.
// [RULE8] Mode one: all outputs change together. With enable high, a half write here changes only its sixteen relays.
// [RULE9] Results captured in edge-triggered latch registers.
// [RULE10] Reset clears latches, mode and enable.
`timescale 1ns/1ps
`include "crol_params.svh"
module crol_top
  import crol_pkg::*;
(
  // Clock and reset.
  input  wire logic        MCLK_IN,
  input  wire logic        NRST_IN,
  // APB slave.
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Relay drive.
  output logic [31:0]      RELAY_OUT
);
  import crol_pkg::*;

  crol_apb_req_s req;
  crol_half_t    low_q;
  crol_half_t    high_q;
  logic          mode_r;
  logic          enable_r;
  logic          ready_r;
  logic [31:0]   prdata_r;
  logic          slverr_r;
  logic [31:0]   relay_r;
  logic [31:0]   relay_nxt;
  logic [31:0]   rd_nxt;

  // Bus request bundle.
  assign req = '{sel: PSEL_IN, en: PENABLE_IN, wr: PWRITE_IN,
                 addr: PADDR_IN, wdata: PWDATA_IN};

  // Access is taken in the first access-phase cycle; the slave answers one cycle later.
  wire acc      = req.sel && req.en && !ready_r;
  wire hit_low  = (req.addr == `CROL_OFF_LOW);
  wire hit_high = (req.addr == `CROL_OFF_HIGH);
  wire hit_set  = (req.addr == `CROL_OFF_SET);
  wire hit_stat = (req.addr == `CROL_OFF_STATUS);
  wire mapped   = hit_low || hit_high || hit_set || hit_stat;
  // Separate strobes for each result half and for the setting register.
  wire wr_low   = acc && req.wr && hit_low;   // [RULE4] [RULE7]
  wire wr_high  = acc && req.wr && hit_high;  // [RULE4] [RULE7]
  wire wr_set   = acc && req.wr && hit_set;   // [RULE4]

  // Read multiplexer; the status word shows mode, enable and a card tag.
  wire [31:0] stat_word = {`CROL_CARD_ID, 14'h0000, enable_r, mode_r};  // [RULE5]
  assign rd_nxt = hit_low  ? {16'h0000, low_q}  :
                  hit_high ? {16'h0000, high_q} :
                  hit_set  ? {30'h0000_0000, enable_r, mode_r} :
                  hit_stat ? stat_word : 32'h0000_0000;

  // Relay value: direct in mode zero, gated by enable in mode one.
  assign relay_nxt = mode_r ? ({high_q, low_q} & {32{enable_r}})  // [RULE3] [RULE8]
                            : {high_q, low_q};                    // [RULE2] [RULE1]

  // Low and high result latches.
  crol_half_latch u_low (
    .clk_in  (MCLK_IN),
    .nrst_in (NRST_IN),
    .load_in (wr_low),
    .data_in (req.wdata[15:0]),
    .q_out   (low_q)
  );
  crol_half_latch u_high (
    .clk_in  (MCLK_IN),
    .nrst_in (NRST_IN),
    .load_in (wr_high),
    .data_in (req.wdata[15:0]),
    .q_out   (high_q)
  );

  // Mode and enable flip-flops, loaded by setting writes.
  always_ff @(posedge MCLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      mode_r   <= 1'b0;  // [RULE10]
      enable_r <= 1'b0;  // [RULE10]
    end
    else if (wr_set)
    begin
      mode_r   <= req.wdata[`CROL_BIT_MODE];    // [RULE6]
      enable_r <= req.wdata[`CROL_BIT_ENABLE];  // [RULE6]
    end
  end

  // Bus answer registers.
  always_ff @(posedge MCLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      ready_r  <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end
    else
    begin
      ready_r  <= acc;
      prdata_r <= (acc && !req.wr) ? rd_nxt : 32'h0000_0000;  // [RULE5]
      slverr_r <= acc && !mapped;
    end
  end

  // Relay output register; all 32 bits update on one edge.
  always_ff @(posedge MCLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      relay_r <= 32'h0000_0000;  // [RULE10]
    else
      relay_r <= relay_nxt;      // [RULE9]
  end

  assign PRDATA_OUT  = prdata_r;
  assign PREADY_OUT  = ready_r;
  assign PSLVERR_OUT = slverr_r;
  assign RELAY_OUT   = relay_r;

  // Mode zero: a low-half write reaches the relays two edges after the strobe.
  property p_direct;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (wr_low && !mode_r && !wr_set) |-> ##2 (RELAY_OUT[15:0] == $past(req.wdata[15:0], 2));
  endproperty
  a_direct: assert property (p_direct) else $error("direct mode low half wrong"); // [RULE2]

  // Mode one: relay equals stored result gated by enable.
  property p_gated;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (mode_r && $stable(mode_r) && $stable(enable_r) && $stable({high_q, low_q}))
        |=> (RELAY_OUT == ($past({high_q, low_q}) & {32{$past(enable_r)}}));
  endproperty
  a_gated: assert property (p_gated) else $error("gated relay value wrong"); // [RULE3]

  // A low-half write never disturbs the high half.
  property p_half;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      wr_low |=> $stable(high_q);
  endproperty
  a_half: assert property (p_half) else $error("high half changed on low write"); // [RULE7]

  // Mode one with enable low keeps every relay open.
  property p_allopen;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (mode_r && !enable_r) ##1 (mode_r && !enable_r) |-> (RELAY_OUT == 32'h0000_0000);
  endproperty
  a_allopen: assert property (p_allopen) else $error("relay closed without enable"); // [RULE8]

  // A setting write loads mode and enable from the data bits.
  property p_setting;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      wr_set |=> (mode_r == $past(req.wdata[0]) && enable_r == $past(req.wdata[1]));
  endproperty
  a_setting: assert property (p_setting) else $error("setting not loaded"); // [RULE6]

  // Each accepted access is answered exactly one cycle later, once.
  property p_answer;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      acc |=> (PREADY_OUT ##1 !PREADY_OUT);
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong"); // [RULE4]

  // Status read returns mode and enable.
  property p_status;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (acc && !req.wr && hit_stat && !wr_set) |=> (PRDATA_OUT[1:0] == {enable_r, mode_r});
  endproperty
  a_status: assert property (p_status) else $error("status read wrong"); // [RULE5]

  // Latch holds when no strobe arrives.
  property p_hold;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      !wr_low |=> (low_q == $past(low_q));
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without strobe"); // [RULE9]

  c_low_write: cover property (@(posedge MCLK_IN) disable iff (!NRST_IN) wr_low);
  c_gated_on:  cover property (@(posedge MCLK_IN) disable iff (!NRST_IN)
                               mode_r && enable_r && RELAY_OUT != 32'h0000_0000);
  c_stat_read: cover property (@(posedge MCLK_IN) disable iff (!NRST_IN)
                               acc && !req.wr && hit_stat);
endmodule

// File: testbench/crol_host_model.sv
// Host bus model that issues APB transfers to the relay output latch.
`timescale 1ns/1ps
module crol_host_model
(
  // Clock.
  input  wire logic        clk_in,
  // APB request.
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  // APB answer.
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  // The bus is idle at time zero.
  initial
  begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'h000;
    pwdata_out  = 32'h0000_0000;
  end

  // One transfer: setup, then access until ready; idle lines show inverted junk.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    begin
      ok = 1'b0;
      @(posedge clk_in);
      psel_out    <= 1'b1;
      pwrite_out  <= wr;
      paddr_out   <= a;
      pwdata_out  <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      for (n = 0; n < 16 && !ok; n++)
      begin
        @(posedge clk_in);
        ok  = (pready_in === 1'b1);
        rd  = prdata_in;
        err = pslverr_in;
      end
      psel_out    <= 1'b0;
      penable_out <= 1'b0;
      paddr_out   <= ~a;
      pwdata_out  <= ~d;
    end
  endtask
endmodule

// File: testbench/tb_crol_top.sv
// Self-checking bench for the comparator relay output latch.
`timescale 1ns/1ps
module tb_crol_top;
  // Clock, reset, bus and relay wires, counters.
  logic        mclk;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, relay;
  logic [31:0] last_rly = 32'h0000_0000;
  logic        timed_out = 1'b0;
  int          checks = 0;
  int          miscompares = 0;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] rly;
                  logic [31:0] rd; logic err;} crol_row_s;
  crol_row_s   rows [13];

  // Design and host model.
  crol_top i_crol_top (.MCLK_IN(mclk), .NRST_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RELAY_OUT(relay));
  crol_host_model i_crol_host_model (.clk_in(mclk), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

  // The 200 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Compares one value and counts it.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      checks++;
      if (got !== exp)
      begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Runs one transfer; relay holds until the answer edge, then shows and keeps the new value.
  task automatic run(input crol_row_s r);
    logic [31:0] rd;
    logic        err;
    logic        ok;
    begin
      if (!timed_out)
      begin
        chk("relay held", last_rly, relay);
        i_crol_host_model.xfer(r.wr, r.a, r.d, rd, err, ok);
        if (!ok)
        begin
          miscompares++;
          $display("[FAIL] pready expected 1 seen 0");
          timed_out = 1'b1;
        end
        else
        begin
          #1;
          chk("read data", r.rd, rd);
          chk("error", {31'h0, r.err}, {31'h0, err});
          chk("relay", r.rly, relay);
          @(posedge mclk);
          #1;
          chk("relay stands", r.rly, relay);
          last_rly = r.rly;
        end
      end
    end
  endtask

  // Reset, table rows, then a reset in mid-run.
  initial
  begin
    rows = '{'{1, 12'h000, 32'hFFFF_1234, 32'h0000_1234, 0, 0},
             '{1, 12'h004, 32'h0000_ABCD, 32'hABCD_1234, 0, 0},
             '{0, 12'h000, 0, 32'hABCD_1234, 32'h0000_1234, 0},
             '{0, 12'h00C, 0, 32'hABCD_1234, 32'hA5C3_0000, 0},
             '{1, 12'h008, 32'h0000_0001, 32'h0000_0000, 0, 0},
             '{1, 12'h000, 32'h0000_00FF, 32'h0000_0000, 0, 0},
             '{0, 12'h00C, 0, 32'h0000_0000, 32'hA5C3_0001, 0},
             '{1, 12'h008, 32'h0000_0003, 32'hABCD_00FF, 0, 0},
             '{1, 12'h010, 32'h1234_5678, 32'hABCD_00FF, 0, 1},
             '{0, 12'h010, 0, 32'hABCD_00FF, 32'h0000_0000, 1},
             '{1, 12'h008, 32'h0000_0002, 32'hABCD_00FF, 0, 0},
             '{0, 12'h004, 0, 32'hABCD_00FF, 32'h0000_ABCD, 0},
             '{0, 12'h008, 0, 32'hABCD_00FF, 32'h0000_0002, 0}};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("relay after reset", 32'h0000_0000, relay);
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    chk("relay in reset", 32'h0000_0000, relay);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    last_rly = 32'h0000_0000;
    run('{0, 12'h008, 0, 32'h0000_0000, 32'h0000_0000, 0});
    $display("reset test done");
    summarize();
  end
endmodule
